// file: bench/bsp_pins_model.sv
`timescale 1ns/1ps
module bsp_pins_model (
  // Control from the bench
  input wire logic clk,
  input wire logic [5:0] strap,
  input wire logic ref_stop,
  // Board pins
  output logic debug_enable_pin,
  output logic break_input_pin,
  output logic [3:0] boot_cfg_pin,
  output logic ext_clk_ref_pin,
  output logic pll_lock_pin
);
  int cnt = 0;
  initial ext_clk_ref_pin = 1'h0;
  // The bench only changes straps well away from a boot sample.
  assign {debug_enable_pin, break_input_pin, boot_cfg_pin} = strap;
  // A dead crystal also costs the PLL its lock.
  assign pll_lock_pin = !ref_stop;
  // A ten cycle reference sits inside the monitor window; stopping it models a dead crystal.
  always @(posedge clk)
  begin
    cnt <= (cnt == 4) ? 0 : cnt + 1;
    if (cnt == 4 && !ref_stop)
      ext_clk_ref_pin <= !ext_clk_ref_pin;
  end
endmodule // bsp_pins_model

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import bsp_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, ref_stop = 0, nmi_n_pin = 1, ext_wake_pin = 0, wdt_event = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, periph_irq = 0, periph_idle = 0, periph_req = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_start, cpu_halt;
  logic pin_tristate, ebu_enable, ebu_master, cpu_clk_en, sys_clk_en, mem_access_en, pll_sel_96;
  logic pll_emergency, debug_enable_pin, break_input_pin, ext_clk_ref_pin, pll_lock_pin;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, boot_pc, rd;
  logic [3:0] s_axi_wstrb = 4'hf, boot_cfg_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] periph_clk_en;
  logic [5:0] strap = 6'h34;
  logic [5:0] st [8] = '{6'h30, 6'h3c, 6'h14, 6'h1c, 6'h11, 6'h20, 6'h03, 6'h31};
  logic [35:0] ex [8] = '{{PC_SCRATCH, 4'h0}, {PC_EXT, 4'h3}, {PC_NONE, 4'ha}, {PC_NONE, 4'hb},
    {PC_NONE, 4'h8}, {PC_NONE, 4'h4}, {PC_EMU, 4'h0}, {PC_ROM, 4'h0}};
  int err_total = 0, num_checks = 0;
  initial
  begin
    forever #5 clk = ~clk;
  end
  bsp_pins_model bsp_pins_model_i (.clk, .strap, .ref_stop, .debug_enable_pin, .break_input_pin,
    .boot_cfg_pin, .ext_clk_ref_pin, .pll_lock_pin);
  bsp_top bsp_top_i (.clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .debug_enable_pin, .break_input_pin, .boot_cfg_pin, .nmi_n_pin, .ext_wake_pin, .ext_clk_ref_pin,
    .pll_lock_pin, .wdt_event, .periph_irq, .periph_idle, .periph_req, .boot_pc, .cpu_start, .cpu_halt,
    .pin_tristate, .ebu_enable, .ebu_master, .cpu_clk_en, .sys_clk_en, .periph_clk_en, .mem_access_en,
    .pll_sel_96, .pll_emergency);
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task fail_wait;
    err_total++;
    report_and_stop;
  endtask
  // Address and data are offered together; each is dropped once its own ready is seen.
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 99 && !s_axi_bvalid; n++)
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    rs = s_axi_bresp;
    if (n == 99) fail_wait;
  endtask
  task rdr(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 99 && !s_axi_rvalid; n++)
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    if (n == 99) fail_wait;
  endtask
  // Polls status; running out of polls is itself a mismatch.
  task wait_st(input logic [31:0] m, input logic [31:0] v);
    int n;
    for (n = 0; n < 60; n++)
    begin
      rdr(ADDR_STATUS);
      if ((rd & m) === v) break;
    end
    if (n == 60) fail_wait;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int i, n;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    wait_st(32'h100, 32'h100);
    chk({boot_pc, cpu_halt, pin_tristate, ebu_enable, ebu_master}, {PC_EXT, 4'h2});
    chk({sys_clk_en, mem_access_en, periph_clk_en}, {2'h3, 8'hff});
    $display("test boot end");
    wr(ADDR_CTRL, 32'h15);
    wait_st(32'h3f, 32'h02);
    chk({cpu_clk_en, mem_access_en, periph_clk_en}, {2'h1, 8'hff});
    wdt_event <= 1;
    @(posedge clk);
    wdt_event <= 0;
    wait_st(32'h3f, 32'h01);
    chk(cpu_clk_en, 1'h1);
    wr(ADDR_PER_EN, 32'h0f);
    @(posedge clk);
    chk(periph_clk_en, 8'h0f);
    periph_idle <= 8'h03;
    periph_req <= 8'h01;
    repeat (2) @(posedge clk);
    chk(periph_clk_en, 8'h0d);
    periph_idle <= 0;
    periph_req <= 0;
    wr(ADDR_SLP_KEEP, 32'h05);
    wr(ADDR_IRQ_EN, 32'hff);
    wr(ADDR_CTRL, 32'h16);
    wait_st(32'h3f, 32'h08);
    chk(periph_clk_en, 8'h05);
    periph_irq <= 8'h02;
    repeat (10) @(posedge clk);
    rdr(ADDR_STATUS);
    chk(rd[5:0], 6'h08);
    periph_irq <= 8'h01;
    wait_st(32'h3f, 32'h01);
    periph_irq <= 0;
    $display("test idle sleep end");
    wr(ADDR_CTRL, 32'h17);
    wait_st(32'h3f, 32'h20);
    chk({sys_clk_en, cpu_clk_en}, 2'h0);
    wdt_event <= 1;
    repeat (10) @(posedge clk);
    wdt_event <= 0;
    rdr(ADDR_STATUS);
    chk(rd[5:0], 6'h20);
    ext_wake_pin <= 1;
    repeat (8) @(posedge clk);
    ext_wake_pin <= 0;
    wait_st(32'h3f, 32'h01);
    wr(ADDR_CTRL, 32'h00);
    @(posedge clk);
    chk(pll_sel_96, 1'h0);
    wr(ADDR_CTRL, 32'h10);
    @(posedge clk);
    chk(pll_sel_96, 1'h1);
    rdr(8'h1c);
    chk(rs, RESP_SLVERR);
    $display("test power end");
    // Straps settle before each software reset so the sample sees them whole.
    for (i = 0; i < 8; i++)
    begin
      strap <= st[i];
      repeat (10) @(posedge clk);
      wr(ADDR_CTRL, 32'h110);
      repeat (20) @(posedge clk);
      wait_st(32'h300, 32'h300);
      chk({boot_pc, cpu_halt, pin_tristate, ebu_enable, ebu_master}, ex[i]);
    end
    wr(ADDR_CTRL, 32'h210);
    repeat (4) @(posedge clk);
    chk(boot_pc, PC_LOADED);
    $display("test boot table end");
    ref_stop <= 1;
    for (n = 0; n < 300 && pll_emergency !== 1'h1; n++) @(posedge clk);
    chk({pll_emergency, pll_sel_96}, 2'h2);
    repeat (80) @(posedge clk);
    rdr(ADDR_FAULT);
    chk(rd[FLT_LOSS], 1'h1);
    chk(rd[FLT_UNLOCK], 1'h1);
    $display("test clock fault end");
    report_and_stop;
  end
endmodule // tb

// file: rtl/bsp_pin_sync.sv
`timescale 1ns/1ps
module bsp_pin_sync #(
  parameter int W = 1
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pins in, settled levels out
  bsp_sync_if.sync port
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_reg;
  logic [W-1:0] agree;

  // The first stage feeds only the second; agreement is judged on stages two and three.
  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stable_reg <= '0;
    end
    else if (ce)
    begin
      s1_reg <= port.raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_reg <= (stable_reg & ~agree) | (s3_reg & agree);
    end
  end

  assign port.stable = stable_reg;
endmodule // bsp_pin_sync

// file: rtl/bsp_pkg.sv
package bsp_pkg;
  // Register bus.
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PER_EN = 8'h04;
  localparam logic [7:0] ADDR_SLP_KEEP = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_BOOT_PC = 8'h14;
  localparam logic [7:0] ADDR_FAULT = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GO = 2;
  localparam int CTRL_PLL96 = 4;
  localparam int CTRL_SW_RST = 8;
  localparam int CTRL_LOADER_OK = 9;
  localparam logic CTRL_PLL96_RST = 1'h1;
  // Fault register fields.
  localparam int FLT_LOSS = 0;
  localparam int FLT_DEV = 1;
  localparam int FLT_UNLOCK = 2;
  // Status register fields.
  localparam int ST_BOOT_VALID = 8;
  localparam int ST_SW_BOOT = 9;
  localparam int ST_HALT = 10;
  localparam int ST_TRI = 11;
  localparam int ST_EBU_EN = 12;
  localparam int ST_EBU_MST = 13;
  localparam int ST_EMERG = 14;
  // Mode request codes.
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_DEEP = 2'h3;
  // Boot selection.
  localparam logic [2:0] CFG_SCRATCH = 3'h0;
  localparam logic [2:0] CFG_EXT = 3'h4;
  localparam logic [31:0] PC_SCRATCH = 32'hd4000000;
  localparam logic [31:0] PC_ROM = 32'hdffffffc;
  localparam logic [31:0] PC_LOADED = 32'hc0000004;
  localparam logic [31:0] PC_EXT = 32'ha0000000;
  localparam logic [31:0] PC_EMU = 32'hde000000;
  localparam logic [31:0] PC_NONE = 32'h00000000;
  // Synchronised pin vector positions.
  localparam int PIN_DBG = 0;
  localparam int PIN_BRK = 1;
  localparam int PIN_CFG = 2;
  localparam int PIN_NMI = 6;
  localparam int PIN_WAKE = 7;
  localparam int PIN_REF = 8;
  localparam int PIN_LOCK = 9;
  localparam int PIN_W = 10;
  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SHUT_TIME_NS = 80;
  localparam logic [3:0] SHUT_CYC = 4'((SHUT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] BOOT_SETTLE_CYC = 3'h5;
  localparam int PLL_HI_MHZ = 96;
  localparam int PLL_LO_MHZ = 48;
  typedef enum logic [5:0] {
    PS_RUN = 6'h01,
    PS_IDLE = 6'h02,
    PS_SLP_SHUT = 6'h04,
    PS_SLEEP = 6'h08,
    PS_DS_SHUT = 6'h10,
    PS_DEEP = 6'h20
  } bsp_pstate_t;
  typedef struct packed {
    logic [31:0] pc;
    logic halt;
    logic tri_st;
    logic ebu_en;
    logic ebu_mst;
  } bsp_boot_t;
endpackage

// file: rtl/bsp_sync_if.sv
`timescale 1ns/1ps
interface bsp_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  modport sync (input raw, output stable);
  modport user (output raw, input stable);
endinterface

// file: rtl/bsp_top.sv
`timescale 1ns/1ps
module bsp_top #(
  parameter int NPER = 8,
  parameter int REF_MIN_CYC = 4,
  parameter int REF_MAX_CYC = 16,
  parameter int REF_LOSS_CYC = 64
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register bus
  input wire logic [bsp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bsp_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic debug_enable_pin,
  input wire logic break_input_pin,
  input wire logic [3:0] boot_cfg_pin,
  input wire logic nmi_n_pin,
  input wire logic ext_wake_pin,
  input wire logic ext_clk_ref_pin,
  input wire logic pll_lock_pin,
  // Same-clock events
  input wire logic wdt_event,
  input wire logic [NPER-1:0] periph_irq,
  input wire logic [NPER-1:0] periph_idle,
  input wire logic [NPER-1:0] periph_req,
  // Boot and power outputs
  output logic [31:0] boot_pc,
  output logic cpu_start,
  output logic cpu_halt,
  output logic pin_tristate,
  output logic ebu_enable,
  output logic ebu_master,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic [NPER-1:0] periph_clk_en,
  output logic mem_access_en,
  output logic pll_sel_96,
  output logic pll_emergency
);
  import bsp_pkg::*;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  function automatic bsp_boot_t boot_decode(input logic dbg, input logic brk, input logic [3:0] cfg,
                                            input logic sw);
    bsp_boot_t b;
    b = '{pc: PC_NONE, halt: 1'b0, tri_st: 1'b0, ebu_en: 1'b0, ebu_mst: 1'b0};
    if (dbg && brk)
    begin
      if (cfg[2:0] == CFG_SCRATCH && sw)
        b.pc = PC_SCRATCH;
      else if (cfg[2:0] == CFG_EXT)
      begin
        b.pc = PC_EXT;
        b.ebu_en = 1'b1;
        b.ebu_mst = cfg[3];
      end
      else
        b.pc = PC_ROM;
    end
    else if (!dbg && brk)
    begin
      b.halt = 1'b1;
      b.ebu_en = (cfg[2:0] == CFG_EXT);
      b.ebu_mst = cfg[3] && (cfg[2:0] == CFG_EXT);
    end
    else if (dbg && !brk)
      b.tri_st = 1'b1;
    else
      b.pc = PC_EMU;
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  bsp_sync_if #(.W(PIN_W)) sif();
  logic [PIN_W-1:0] pins;
  assign sif.raw = {pll_lock_pin, ext_clk_ref_pin, ext_wake_pin, nmi_n_pin, boot_cfg_pin, break_input_pin,
                    debug_enable_pin};
  assign pins = sif.stable;

  bsp_pin_sync #(.W(PIN_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .port(sif.sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register bus slave.
  logic aw_have_reg, w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_en;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [1:0] mode_field_reg;
  logic pll96_reg;
  logic [NPER-1:0] per_en_reg, slp_keep_reg, irq_en_reg;
  logic [2:0] fault_reg;
  logic [2:0] fault_set;
  bsp_pstate_t pstate_reg, pstate_next;
  logic boot_valid_reg, sw_boot_reg;

  assign wr_en = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_val = merge_strb(32'h0, w_data_reg, w_strb_reg);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg[7:2] <= ADDR_FAULT[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb
  begin
    rd_ok = 1'b1;
    rd_val = 32'h0;
    case (s_axi_araddr[7:2])
      ADDR_CTRL[7:2]: rd_val = 32'({pll96_reg, 2'h0, mode_field_reg});
      ADDR_PER_EN[7:2]: rd_val = 32'(per_en_reg);
      ADDR_SLP_KEEP[7:2]: rd_val = 32'(slp_keep_reg);
      ADDR_IRQ_EN[7:2]: rd_val = 32'(irq_en_reg);
      ADDR_STATUS[7:2]: rd_val = 32'({pll_emergency, ebu_master, ebu_enable, pin_tristate, cpu_halt,
                                      sw_boot_reg, boot_valid_reg, 2'h0, pstate_reg});
      ADDR_BOOT_PC[7:2]: rd_val = boot_pc;
      ADDR_FAULT[7:2]: rd_val = 32'(fault_reg);
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software-visible control.
  logic wr_ctrl, mode_go, soft_rst, loader_ok, wr_fault;
  assign wr_ctrl = wr_en && aw_addr_reg[7:2] == ADDR_CTRL[7:2];
  assign wr_fault = wr_en && aw_addr_reg[7:2] == ADDR_FAULT[7:2];
  assign mode_go = wr_ctrl && wr_val[CTRL_GO];
  assign soft_rst = wr_ctrl && wr_val[CTRL_SW_RST];
  assign loader_ok = wr_ctrl && wr_val[CTRL_LOADER_OK];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_field_reg <= MODE_RUN;
      pll96_reg <= CTRL_PLL96_RST;
      per_en_reg <= '1;
      slp_keep_reg <= '0;
      irq_en_reg <= '0;
    end
    else if (ce && wr_en)
    begin
      if (wr_ctrl)
      begin
        mode_field_reg <= wr_val[CTRL_MODE_LSB +: 2];
        pll96_reg <= wr_val[CTRL_PLL96];
      end
      if (aw_addr_reg[7:2] == ADDR_PER_EN[7:2])
        per_en_reg <= wr_val[NPER-1:0];
      if (aw_addr_reg[7:2] == ADDR_SLP_KEEP[7:2])
        slp_keep_reg <= wr_val[NPER-1:0];
      if (aw_addr_reg[7:2] == ADDR_IRQ_EN[7:2])
        irq_en_reg <= wr_val[NPER-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Boot selection.
  logic [2:0] boot_cnt_reg;
  logic boot_latch;
  bsp_boot_t boot_sel;
  logic [5:0] cap_reg;
  assign boot_latch = !boot_valid_reg && boot_cnt_reg == BOOT_SETTLE_CYC;
  assign boot_sel = boot_decode(pins[PIN_DBG], pins[PIN_BRK], pins[PIN_CFG +: 4], sw_boot_reg);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      boot_cnt_reg <= 3'h0;
      boot_valid_reg <= 1'b0;
      sw_boot_reg <= 1'b0;
      cap_reg <= 6'h0;
      boot_pc <= PC_NONE;
      cpu_start <= 1'b0;
      cpu_halt <= 1'b0;
      pin_tristate <= 1'b0;
      ebu_enable <= 1'b0;
      ebu_master <= 1'b0;
    end
    else if (ce)
    begin
      cpu_start <= 1'b0;
      if (soft_rst)
      begin
        boot_cnt_reg <= 3'h0;
        boot_valid_reg <= 1'b0;
        sw_boot_reg <= 1'b1;
        // The old result is dropped so a tri-state boot cannot drag the new run back into deep sleep.
        boot_pc <= PC_NONE;
        cpu_halt <= 1'b0;
        pin_tristate <= 1'b0;
        ebu_enable <= 1'b0;
        ebu_master <= 1'b0;
      end
      else if (boot_latch)
      begin
        // Pins have passed the synchroniser by now, so the captured levels are settled.
        boot_valid_reg <= 1'b1;
        cap_reg <= pins[PIN_CFG+3:PIN_DBG];
        boot_pc <= boot_sel.pc;
        cpu_halt <= boot_sel.halt;
        pin_tristate <= boot_sel.tri_st;
        ebu_enable <= boot_sel.ebu_en;
        ebu_master <= boot_sel.ebu_mst;
        cpu_start <= !boot_sel.halt && !boot_sel.tri_st;
      end
      else if (!boot_valid_reg)
        boot_cnt_reg <= boot_cnt_reg + 3'h1;
      else if (loader_ok && boot_pc == PC_ROM)
      begin
        boot_pc <= PC_LOADED;
        cpu_start <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power state machine.
  logic nmi_prev_reg, wake_prev_reg, nmi_fall, ext_wake;
  logic wake_idle, wake_sleep;
  logic [3:0] shut_cnt_reg;
  assign nmi_fall = nmi_prev_reg && !pins[PIN_NMI];
  assign ext_wake = pins[PIN_WAKE] && !wake_prev_reg;
  assign wake_idle = nmi_fall || wdt_event || |(periph_irq & irq_en_reg);
  assign wake_sleep = nmi_fall || wdt_event || |(periph_irq & irq_en_reg & slp_keep_reg);

  always_comb
  begin
    pstate_next = pstate_reg;
    if (soft_rst)
      pstate_next = PS_RUN;
    else if (pin_tristate)
      pstate_next = PS_DEEP;
    else
      case (pstate_reg)
        PS_RUN:
          if (mode_go)
            case (wr_val[CTRL_MODE_LSB +: 2])
              MODE_IDLE: pstate_next = PS_IDLE;
              MODE_SLEEP: pstate_next = PS_SLP_SHUT;
              MODE_DEEP: pstate_next = PS_DS_SHUT;
              default: pstate_next = PS_RUN;
            endcase
        PS_IDLE:
          if (wake_idle)
            pstate_next = PS_RUN;
        PS_SLP_SHUT:
          if (wake_sleep)
            pstate_next = PS_RUN;
          else if (shut_cnt_reg == 4'h0)
            pstate_next = PS_SLEEP;
        PS_SLEEP:
          if (wake_sleep)
            pstate_next = PS_RUN;
        PS_DS_SHUT:
          if (shut_cnt_reg == 4'h0)
            pstate_next = PS_DEEP;
        PS_DEEP:
          if (ext_wake)
            pstate_next = PS_RUN;
        default: pstate_next = PS_RUN;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pstate_reg <= PS_RUN;
      shut_cnt_reg <= SHUT_CYC;
      nmi_prev_reg <= 1'b0;
      wake_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      pstate_reg <= pstate_next;
      nmi_prev_reg <= pins[PIN_NMI];
      wake_prev_reg <= pins[PIN_WAKE];
      // The shutdown count restarts on every entry so each sequence runs its full length.
      if (pstate_next != pstate_reg)
        shut_cnt_reg <= SHUT_CYC;
      else if (shut_cnt_reg != 4'h0)
        shut_cnt_reg <= shut_cnt_reg - 4'h1;
    end
  end

  // Clock enables follow the next state so they line up with the state register.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cpu_clk_en <= 1'b0;
      sys_clk_en <= 1'b1;
      periph_clk_en <= '0;
      mem_access_en <= 1'b1;
    end
    else if (ce)
    begin
      cpu_clk_en <= pstate_next == PS_RUN && boot_valid_reg && !cpu_halt;
      sys_clk_en <= pstate_next != PS_DEEP;
      mem_access_en <= pstate_next == PS_RUN || pstate_next == PS_IDLE;
      case (pstate_next)
        PS_RUN: periph_clk_en <= per_en_reg & (~periph_idle | periph_req);
        PS_IDLE: periph_clk_en <= '1;
        PS_SLP_SHUT: periph_clk_en <= per_en_reg;
        PS_SLEEP: periph_clk_en <= slp_keep_reg;
        PS_DS_SHUT: periph_clk_en <= per_en_reg;
        default: periph_clk_en <= '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reference clock monitor and PLL control.
  logic ref_prev_reg, lock_prev_reg, lock_seen_reg, ref_rise, lock_fell;
  logic ref_armed_reg;
  logic [15:0] per_cnt_reg;
  assign ref_rise = pins[PIN_REF] && !ref_prev_reg;
  assign lock_fell = lock_seen_reg && lock_prev_reg && !pins[PIN_LOCK];
  assign fault_set[FLT_LOSS] = boot_valid_reg && per_cnt_reg == 16'(REF_LOSS_CYC);
  assign fault_set[FLT_DEV] = boot_valid_reg && ref_armed_reg && ref_rise &&
                              (per_cnt_reg < 16'(REF_MIN_CYC) || per_cnt_reg > 16'(REF_MAX_CYC));
  assign fault_set[FLT_UNLOCK] = lock_fell;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ref_prev_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
      lock_seen_reg <= 1'b0;
      ref_armed_reg <= 1'b0;
      per_cnt_reg <= 16'h0;
      fault_reg <= 3'h0;
      pll_emergency <= 1'b0;
      pll_sel_96 <= CTRL_PLL96_RST;
    end
    else if (ce)
    begin
      ref_prev_reg <= pins[PIN_REF];
      lock_prev_reg <= pins[PIN_LOCK];
      lock_seen_reg <= lock_seen_reg || pins[PIN_LOCK];
      // The first period after the monitor starts is partial, so deviation is judged only from the next edge.
      if (!boot_valid_reg)
        ref_armed_reg <= 1'b0;
      else if (ref_rise)
        ref_armed_reg <= 1'b1;
      if (ref_rise || !boot_valid_reg)
        per_cnt_reg <= 16'h0;
      else if (per_cnt_reg != 16'(REF_LOSS_CYC))
        per_cnt_reg <= per_cnt_reg + 16'h1;
      // A fault that arrives together with its clear stays set.
      fault_reg <= (fault_reg & ~(wr_fault ? wr_val[2:0] : 3'h0)) | fault_set;
      pll_emergency <= |fault_set || |(fault_reg & ~(wr_fault ? wr_val[2:0] : 3'h0));
      // The emergency action falls back to the slower clock.
      pll_sel_96 <= pll96_reg && !(|fault_set) && !pll_emergency;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_scratch_sw_only: assert property (@(posedge clk) disable iff (!rst_n)
    boot_valid_reg && boot_pc == PC_SCRATCH |-> sw_boot_reg && cap_reg[PIN_CFG +: 3] == CFG_SCRATCH)
    else $error("scratchpad boot without software reset");
  chk_ext_boot_bus: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(boot_valid_reg) && cap_reg[1:0] == 2'h3 && cap_reg[4:2] == CFG_EXT
    |-> boot_pc == PC_EXT && ebu_enable && ebu_master == cap_reg[5])
    else $error("external boot bus role wrong");
  chk_halt_boot: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(boot_valid_reg) && cap_reg[1:0] == 2'h2 |-> cpu_halt && !cpu_start ##1 !cpu_clk_en)
    else $error("halt boot did not halt");
  chk_emu_boot_pc: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(boot_valid_reg) && cap_reg[1:0] == 2'h0 |-> boot_pc == PC_EMU && cpu_start)
    else $error("emulator boot address wrong");
  chk_tristate_deep: assert property (@(posedge clk) disable iff (!rst_n)
    ce && pin_tristate && !soft_rst |=> pstate_reg == PS_DEEP && !sys_clk_en)
    else $error("tri-state boot left deep sleep");
  chk_idle_clocks: assert property (@(posedge clk) disable iff (!rst_n)
    pstate_reg == PS_IDLE |-> !cpu_clk_en && &periph_clk_en && mem_access_en)
    else $error("idle clocks wrong");
  chk_idle_wake: assert property (@(posedge clk) disable iff (!rst_n)
    ce && pstate_reg == PS_IDLE && wake_idle && !pin_tristate |=> pstate_reg == PS_RUN)
    else $error("idle missed wake event");
  chk_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pstate_reg == PS_SLEEP) |-> $past(pstate_reg) == PS_SLP_SHUT)
    else $error("sleep entered without shutdown");
  chk_deep_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ce && pstate_reg == PS_DEEP && !ext_wake && !soft_rst |=> pstate_reg == PS_DEEP)
    else $error("deep sleep left without external wake");
  chk_unlock_emerg: assert property (@(posedge clk) disable iff (!rst_n)
    ce && lock_fell |=> pll_emergency && fault_reg[FLT_UNLOCK] && !pll_sel_96)
    else $error("lock loss raised no emergency");
endmodule // bsp_top
